// [rtl/pcb_pkg.sv]
// package for the pwm chop, state-blank and time-base capture block
// assumes a 32-bit axi4-lite register bus and a 16-bit time-base count
package pcb_pkg;

  // register byte offsets
  localparam logic [7:0] PCB_OFS_AUX     = 8'h00;
  localparam logic [7:0] PCB_OFS_CAPTURE = 8'h04;
  localparam logic [7:0] PCB_OFS_STATUS  = 8'h08;

  // aux control field positions
  localparam int PCB_LOW_CHOP_BIT   = 0;
  localparam int PCB_HIGH_CHOP_BIT  = 1;
  localparam int PCB_CHOP_SEL_LSB   = 2;
  localparam int PCB_BLANK_SEL_LSB  = 8;
  localparam int PCB_SEL_W          = 4;

  // capture field layout
  localparam int PCB_CAP_LSB = 3;
  localparam int PCB_CAP_W   = 13;

  // reset values
  localparam logic [15:0] PCB_AUX_RESET = 16'h0000;
  localparam logic [15:0] PCB_CAP_RESET = 16'h0000;

  // aux bits that exist; reserved and uncovered bits stay zero
  localparam logic [15:0] PCB_AUX_WMASK = 16'h0F3F;

  // source select codes
  localparam logic [3:0] PCB_SEL_NONE = 4'h0;
  localparam logic [3:0] PCB_SEL_GEN1 = 4'h1;
  localparam logic [3:0] PCB_SEL_GEN2 = 4'h2;
  localparam logic [3:0] PCB_SEL_GEN3 = 4'h3;

  // axi responses
  localparam logic [1:0] PCB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PCB_RESP_SLVERR = 2'h2;

  // capture resolution, eight time-base steps
  localparam real PCB_CAP_STEP_NS = 8.32;

  // chop output group
  typedef struct packed {
    logic primary_output;
    logic secondary_output;
  } pcb_pwm_pair_t;

  // blank enables
  typedef struct packed {
    logic blank_high_enable;
    logic blank_low_enable;
  } pcb_blank_en_t;

  // bus write handshake state
  typedef enum logic [1:0] {
    PCB_W_IDLE = 2'b00,
    PCB_W_RESP = 2'b01
  } pcb_wstate_t;

endpackage

// [rtl/pcb_src_mux.sv]
// source selector: picks one of three generator high outputs by code
// assumes the generator outputs are already on the pwm clock
`timescale 1ns/1ns
`default_nettype none
module pcb_src_mux
  import pcb_pkg::*;
(
  input  wire logic [3:0] sel,
  input  wire logic [2:0] gen_high,
  output var  logic       src_active
);
  // code decode, none and reserved give inactive
  always_comb begin
    case (sel)
      PCB_SEL_NONE: src_active = 1'b0;
      PCB_SEL_GEN1: src_active = gen_high[0];
      PCB_SEL_GEN2: src_active = gen_high[1];
      PCB_SEL_GEN3: src_active = gen_high[2];
      default:      src_active = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/pcb_top.sv]
// top of the chop, state-blank and time-base capture logic with axi4-lite regs
// assumes generator outputs, limit and fault inputs are synchronous to aclk;
// the limit input given here is already past leading-edge blanking
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
//
// Function
// - selected blank source masks limit and fault inputs when their blank enable set
// - blank select 0001, 0010, 0011 pick generator one, two, three high outputs
// - selected chop source gates each output whose chop enable is set
// - chop select 0001 to 0011 pick generators one to three; 0100 to 1111 reserved
// - leading edge on limit input stores time-base count into 13-bit field
// - three low capture register bits always read zero
// - capture works only from the primary high output path
// - capture uses limit signal after leading-edge blanking is done
// - captured value resolution is eight time-base steps, 8.32 ns
module pcb_top
  import pcb_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clk_en,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // channel side
  input  wire logic [2:0]            gen_high,
  input  wire pcb_pkg::pcb_pwm_pair_t pwm_in,
  input  wire pcb_pkg::pcb_blank_en_t blank_en,
  input  wire logic                  ext_period_reset_sel,
  input  wire logic                  limit_in,
  input  wire logic                  fault_in,
  input  wire logic [15:0]           time_base,
  output var  pcb_pkg::pcb_pwm_pair_t pwm_out,
  output var  logic                  limit_out,
  output var  logic                  fault_out
);
  import pcb_pkg::*;

  // refuse address widths that cannot hold the 8-bit register offsets
  if (ADDR_W < 8) begin : g_addr_w_check
    $error("pcb_top: ADDR_W below 8 cannot decode the register offsets");
  end
  // the capture field and its zero bits must fill the whole register
  if (PCB_CAP_LSB + PCB_CAP_W != $bits(PCB_CAP_RESET)) begin : g_cap_w_check
    $error("pcb_top: capture field does not fill the register");
  end

  // aux control and capture registers
  logic [15:0]  aux_r, aux_nxt;
  logic [15:0]  cap_r, cap_nxt;
  logic         limit_prev_r, limit_prev_nxt;
  pcb_pwm_pair_t pwm_out_nxt;
  logic         limit_out_nxt, fault_out_nxt;

  // bus state
  logic                aw_held_r, aw_held_nxt;
  logic                w_held_r, w_held_nxt;
  logic [ADDR_W-1:0]   awaddr_r, awaddr_nxt;
  logic [31:0]         wdata_r, wdata_nxt;
  logic [3:0]          wstrb_r, wstrb_nxt;
  logic                awready_nxt, wready_nxt, bvalid_nxt;
  logic [1:0]          bresp_nxt;
  logic                arready_nxt, rvalid_nxt;
  logic [31:0]         rdata_nxt;
  logic [1:0]          rresp_nxt;
  pcb_wstate_t         wstate_r, wstate_nxt;

  // aux map: [11:8] blank source code, [5:2] chop source code,
  // [1] chop the high output, [0] chop the low output; the rest reads 0
  // field views
  logic [3:0] blank_source_select;
  logic [3:0] chop_source_select;
  logic       high_chop_enable;
  logic       low_chop_enable;
  logic       blank_src, chop_src;
  logic [PCB_CAP_W-1:0] captured_count;
  logic       chop_sel_on;
  logic       high_gate, low_gate;
  logic       cap_edge;

  assign blank_source_select = aux_r[PCB_BLANK_SEL_LSB +: PCB_SEL_W];
  assign chop_source_select  = aux_r[PCB_CHOP_SEL_LSB +: PCB_SEL_W];
  assign high_chop_enable    = aux_r[PCB_HIGH_CHOP_BIT];
  assign low_chop_enable     = aux_r[PCB_LOW_CHOP_BIT];
  assign captured_count      = cap_r[PCB_CAP_LSB +: PCB_CAP_W];

  // both decoders share one module so blank and chop read the same codes;
  // none and reserved codes decode as an inactive source
  // blank source decode
  pcb_src_mux u_blank_mux (
    .sel        (blank_source_select),
    .gen_high   (gen_high),
    .src_active (blank_src)
  );

  // chop clock source decode
  pcb_src_mux u_chop_mux (
    .sel        (chop_source_select),
    .gen_high   (gen_high),
    .src_active (chop_src)
  );

  // output gating, masking and capture edge detect
  // a chop enable only bites while a source code is selected, so code
  // 0000 leaves both outputs untouched whatever the enable bits say
  always_comb begin
    chop_sel_on    = (chop_source_select != PCB_SEL_NONE);
    high_gate      = ~(high_chop_enable & chop_sel_on) | chop_src;
    low_gate       = ~(low_chop_enable & chop_sel_on) | chop_src;
    pwm_out_nxt.primary_output   = pwm_in.primary_output & high_gate;
    pwm_out_nxt.secondary_output = pwm_in.secondary_output & low_gate;
    limit_out_nxt  = limit_in & ~(blank_en.blank_high_enable & blank_src);
    fault_out_nxt  = fault_in & ~(blank_en.blank_low_enable & blank_src);
    limit_prev_nxt = limit_in;
    // limit_in comes after leading-edge blanking on the high output path,
    // so a blanked spike never shows here as an edge
    cap_edge       = limit_in & ~limit_prev_r;
    cap_nxt        = cap_r;
    // low time-base bits are dropped: one stored step is the coarse step
    if (cap_edge) begin
      cap_nxt = {time_base[PCB_CAP_LSB +: PCB_CAP_W], {PCB_CAP_LSB{1'b0}}};
    end
  end

  // axi write channel: address and data may come in either order or
  // together; each is parked until its partner is in, then the aux
  // register is updated and the response raised one cycle later.
  // both readies stay low until the response is taken, which keeps
  // one write in flight and needs no queue
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    wstate_nxt  = wstate_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    aux_nxt     = aux_r;
    awready_nxt = 1'b0;
    wready_nxt  = 1'b0;
    case (wstate_r)
      PCB_W_IDLE: begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_held_nxt = 1'b1;
          awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_held_nxt = 1'b1;
          wdata_nxt  = s_axi_wdata;
          wstrb_nxt  = s_axi_wstrb;
        end
        awready_nxt = ~aw_held_nxt & ~(s_axi_awvalid & s_axi_awready);
        wready_nxt  = ~w_held_nxt & ~(s_axi_wvalid & s_axi_wready);
        if (aw_held_r & w_held_r) begin
          awready_nxt = 1'b0;
          wready_nxt  = 1'b0;
          bresp_nxt   = PCB_RESP_OKAY;
          // capture and status ignore writes but still answer okay
          if (awaddr_r[7:0] == PCB_OFS_AUX) begin
            if (wstrb_r[0]) aux_nxt[7:0]  = wdata_r[7:0] & PCB_AUX_WMASK[7:0];
            if (wstrb_r[1]) aux_nxt[15:8] = wdata_r[15:8] & PCB_AUX_WMASK[15:8];
          end else if (awaddr_r[7:0] != PCB_OFS_CAPTURE &&
                       awaddr_r[7:0] != PCB_OFS_STATUS) begin
            bresp_nxt = PCB_RESP_SLVERR;
          end
          bvalid_nxt  = 1'b1;
          aw_held_nxt = 1'b0;
          w_held_nxt  = 1'b0;
          wstate_nxt  = PCB_W_RESP;
        end
      end
      // response stands until bready, then both readies reopen
      PCB_W_RESP: begin
        if (s_axi_bready) begin
          bvalid_nxt  = 1'b0;
          awready_nxt = 1'b1;
          wready_nxt  = 1'b1;
          wstate_nxt  = PCB_W_IDLE;
        end
      end
      default: wstate_nxt = PCB_W_IDLE;
    endcase
  end

  // read channel: data one cycle after the address, held until rready;
  // arready stays low meanwhile so only one read is ever in flight
  always_comb begin
    arready_nxt = s_axi_arready;
    rvalid_nxt  = s_axi_rvalid;
    rdata_nxt   = s_axi_rdata;
    rresp_nxt   = s_axi_rresp;
    if (s_axi_rvalid & s_axi_rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end else if (s_axi_arvalid & s_axi_arready) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = PCB_RESP_OKAY;
      case (s_axi_araddr[7:0])
        PCB_OFS_AUX:     rdata_nxt = {16'h0000, aux_r};
        // status: [3] period reset option, [2] chop source, [1] blank source,
        // [0] last limit sample
        PCB_OFS_CAPTURE: rdata_nxt = {16'h0000, captured_count, {PCB_CAP_LSB{1'b0}}};
        PCB_OFS_STATUS:  rdata_nxt = {28'h000_0000, ext_period_reset_sel,
                                      chop_src, blank_src, limit_prev_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = PCB_RESP_SLVERR;
        end
      endcase
    end
  end

  // channel registers; clk_en low freezes them together with the bus
  // state so gating and capture stay in step with the register view
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_r          <= PCB_CAP_RESET;
      limit_prev_r   <= 1'b0;
      pwm_out        <= '0;
      limit_out      <= 1'b0;
      fault_out      <= 1'b0;
    end else if (clk_en) begin
      cap_r          <= cap_nxt;
      limit_prev_r   <= limit_prev_nxt;
      pwm_out        <= pwm_out_nxt;
      limit_out      <= limit_out_nxt;
      fault_out      <= fault_out_nxt;
    end
  end

  // write channel and aux registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_r          <= PCB_AUX_RESET;
      aw_held_r      <= 1'b0;
      w_held_r       <= 1'b0;
      awaddr_r       <= '0;
      wdata_r        <= 32'h0000_0000;
      wstrb_r        <= 4'h0;
      wstate_r       <= PCB_W_IDLE;
      s_axi_awready  <= 1'b1;
      s_axi_wready   <= 1'b1;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= PCB_RESP_OKAY;
    end else if (clk_en) begin
      aux_r          <= aux_nxt;
      aw_held_r      <= aw_held_nxt;
      w_held_r       <= w_held_nxt;
      awaddr_r       <= awaddr_nxt;
      wdata_r        <= wdata_nxt;
      wstrb_r        <= wstrb_nxt;
      wstate_r       <= wstate_nxt;
      s_axi_awready  <= awready_nxt;
      s_axi_wready   <= wready_nxt;
      s_axi_bvalid   <= bvalid_nxt;
      s_axi_bresp    <= bresp_nxt;
    end
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready  <= 1'b1;
      s_axi_rvalid   <= 1'b0;
      s_axi_rdata    <= 32'h0000_0000;
      s_axi_rresp    <= PCB_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready  <= arready_nxt;
      s_axi_rvalid   <= rvalid_nxt;
      s_axi_rdata    <= rdata_nxt;
      s_axi_rresp    <= rresp_nxt;
    end
  end
endmodule
`default_nettype wire

// [tb/pcb_checker.sv]
// checker for pcb_top ports: bus timing, gating, masking, capture reads
// assumes one aclk domain, aresetn synchronous active low, clk_en high
`timescale 1ns/1ns
`default_nettype none
module pcb_checker
  import pcb_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic [ADDR_W-1:0]      s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   s_axi_rvalid,
  input wire pcb_pkg::pcb_pwm_pair_t pwm_in,
  input wire pcb_pkg::pcb_blank_en_t blank_en,
  input wire logic                   limit_in,
  input wire logic                   fault_in,
  input wire pcb_pkg::pcb_pwm_pair_t pwm_out,
  input wire logic                   limit_out,
  input wire logic                   fault_out
);
  import pcb_pkg::*;
  logic [ADDR_W-1:0] ar_r;
  // last accepted read address
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_r <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  lim_pass_a:
    assert property ($past(aresetn) && !$past(blank_en.blank_high_enable)
      |-> limit_out == $past(limit_in)) else $error("limit not passed");
  flt_pass_a:
    assert property ($past(aresetn) && !$past(blank_en.blank_low_enable)
      |-> fault_out == $past(fault_in)) else $error("fault not passed");
  in_mask_a:
    assert property (({limit_out, fault_out} & ~{$past(limit_in), $past(fault_in)}) == 2'h0)
      else $error("mask raised an input");
  chop_gate_a:
    assert property ((pwm_out & ~$past(pwm_in)) == 2'h0) else $error("chop raised an output");
  rd_lat_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late rvalid");
  wr_lat_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("late bvalid");
  ar_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during rvalid");
  aw_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready during bvalid");
  cap_low_a:
    assert property (s_axi_rvalid && ar_r == PCB_OFS_CAPTURE |-> s_axi_rdata[2:0] == 3'h0)
      else $error("capture low bits set");
  cover property (s_axi_rvalid && ar_r == PCB_OFS_CAPTURE);
  cover property (limit_in && !$past(limit_in));
  cover property (blank_en.blank_high_enable && !limit_out && $past(limit_in));
endmodule
bind pcb_top pcb_checker #(.ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .pwm_in, .blank_en,
  .limit_in, .fault_in, .pwm_out, .limit_out, .fault_out);
`default_nettype wire

// [tb/pwm_chop_blank_capture_tb.sv]
// testbench for pcb_top: register bus, chop, state blank and capture
// assumes pcb_checker is bound to pcb_top; clk_en and strobes tied
`timescale 1ns/1ns
`default_nettype none
module pwm_chop_blank_capture_tb;
  import pcb_pkg::*;
  logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, limit_in, fault_in;
  logic          awready, wready, bvalid, arready, rvalid, limit_out, fault_out;
  logic [7:0]    awaddr, araddr;
  logic [31:0]   wdata, rdata;
  logic [1:0]    bresp, rresp;
  logic [2:0]    gen_high;
  logic [15:0]   time_base;
  pcb_pwm_pair_t pwm_in, pwm_out;
  pcb_blank_en_t blank_en;
  int            bad_count, num_checks;
  // device under test; period reset option held clear
  pcb_top dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gen_high(gen_high), .pwm_in(pwm_in), .blank_en(blank_en),
    .ext_period_reset_sel(1'b0),
    .limit_in(limit_in), .fault_in(fault_in), .time_base(time_base), .pwm_out(pwm_out),
    .limit_out(limit_out), .fault_out(fault_out));
  always #10 aclk = ~aclk;
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // settle two edges, then compare {pwm_out, limit_out, fault_out}
  task automatic port_chk(input logic [3:0] exp);
    repeat (2) @(posedge aclk);
    chk32({28'h0, pwm_out, limit_out, fault_out}, {28'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_resp(a, d, PCB_RESP_OKAY);
  endtask
  task automatic wr_resp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !bvalid; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n == 50) begin
      bad_count++;
      report_and_stop();
    end
    chk32({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && !rvalid; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (n == 50) begin
      bad_count++;
      report_and_stop();
    end
    chk32(rdata, ed);
    chk32({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task automatic t_regs;
    rdc(PCB_OFS_AUX, 32'h0000_0000, PCB_RESP_OKAY);
    rdc(PCB_OFS_CAPTURE, 32'h0000_0000, PCB_RESP_OKAY);
    rdc(8'h0C, 32'h0000_0000, PCB_RESP_SLVERR);
    wr_resp(8'h0C, 32'h0000_0001, PCB_RESP_SLVERR);
  endtask
  task automatic t_chop;
    pwm_in <= 2'h3;
    for (int k = 1; k < 4; k++) begin
      wr(PCB_OFS_AUX, 32'(k << 2) | 32'h0000_0003);
      gen_high <= 3'(1 << (k - 1));
      port_chk(4'hC);
      gen_high <= ~3'(1 << (k - 1));
      port_chk(4'h0);
      wr(PCB_OFS_AUX, 32'(k << 2) | 32'h0000_0002);
      port_chk(4'h4);
    end
    wr(PCB_OFS_AUX, 32'h0000_0003);
    gen_high <= 3'h0;
    port_chk(4'hC);
    rdc(PCB_OFS_AUX, 32'h0000_0003, PCB_RESP_OKAY);
  endtask
  task automatic t_blank;
    pwm_in <= 2'h0;
    limit_in <= 1'b1;
    fault_in <= 1'b1;
    blank_en <= 2'h3;
    for (int k = 1; k < 4; k++) begin
      wr(PCB_OFS_AUX, 32'(k << 8));
      gen_high <= 3'(1 << (k - 1));
      port_chk(4'h0);
      gen_high <= ~3'(1 << (k - 1));
      port_chk(4'h3);
    end
    gen_high <= 3'h4;
    blank_en <= 2'h1;
    port_chk(4'h2);
    wr(PCB_OFS_AUX, 32'h0000_0000);
    blank_en <= 2'h3;
    port_chk(4'h3);
  endtask
  task automatic t_capture;
    limit_in <= 1'b0;
    blank_en <= 2'h0;
    time_base <= 16'hABCD;
    repeat (2) @(posedge aclk);
    limit_in <= 1'b1;
    @(posedge aclk);
    time_base <= 16'h1234;
    repeat (2) @(posedge aclk);
    rdc(PCB_OFS_CAPTURE, 32'h0000_ABC8, PCB_RESP_OKAY);
    limit_in <= 1'b0;
    repeat (2) @(posedge aclk);
    limit_in <= 1'b1;
    repeat (2) @(posedge aclk);
    wr(PCB_OFS_CAPTURE, 32'hFFFF_FFFF);
    rdc(PCB_OFS_CAPTURE, 32'h0000_1230, PCB_RESP_OKAY);
    rdc(PCB_OFS_STATUS, 32'h0000_0001, PCB_RESP_OKAY);
  endtask
  // reserved aux bits read zero; a mid-run reset clears aux and capture
  task automatic t_reset;
    limit_in <= 1'b0;
    wr(PCB_OFS_AUX, 32'hFFFF_FFFF);
    rdc(PCB_OFS_AUX, 32'h0000_0F3F, PCB_RESP_OKAY);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(PCB_OFS_AUX, 32'h0000_0000, PCB_RESP_OKAY);
    rdc(PCB_OFS_CAPTURE, 32'h0000_0000, PCB_RESP_OKAY);
  endtask
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, limit_in, fault_in} = '0;
    {awaddr, araddr, wdata, gen_high, time_base, pwm_in, blank_en} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_chop();
    t_blank();
    t_capture();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
